// file: design/qdsl_shift_chan.sv
// Package of shared constants and one channel's serial shift register on its link clock
package qdsl_pkg;
	localparam int unsigned QDSL_WORD_W = 12;
	localparam int unsigned QDSL_NUM_CH = 4;
	localparam int unsigned QDSL_SYNC_STAGES = 2;
	localparam logic [11:0] QDSL_WORD_RST = 12'h000;
	localparam logic QDSL_STROBE_RST = 1'b1;
	localparam int unsigned QDSL_SYS_PERIOD_NS = 5;
endpackage

module qdsl_shift_chan
	import qdsl_pkg::*;
#(
	parameter int unsigned WORD_W = QDSL_WORD_W
) (
	input wire logic link_clk,
	input wire logic rst_b,
	input wire logic ser_in,
	output logic [WORD_W-1:0] word
);
	logic rs1_q;
	logic rs2_q;
	logic rs1_d;
	logic rs2_d;
	logic [WORD_W-1:0] sr_q;
	logic [WORD_W-1:0] sr_d;

	// Reset asserts at once, releases on the link clock
	always_comb begin
		rs1_d = 1'b1;
		rs2_d = rs1_q;
	end

	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
		end else begin
			rs1_q <= rs1_d;
			rs2_q <= rs2_d;
		end
	end

	// MSB arrives first, so shift toward the top
	always_comb begin
		sr_d = {sr_q[WORD_W-2:0], ser_in};
	end

	always_ff @(posedge link_clk or negedge rs2_q) begin
		if (!rs2_q) begin
			sr_q <= WORD_W'(QDSL_WORD_RST);
		end else begin
			sr_q <= sr_d;
		end
	end

	assign word = sr_q;
endmodule

// file: design/qdsl_top.sv
// Four-channel serial load front end: shift registers, strobe sync and holding registers
module qdsl_top #(
	parameter bit SHARED_CLK = 1'b0
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic shift_clk_a,
	input wire logic shift_clk_b,
	input wire logic shift_clk_c,
	input wire logic shift_clk_d,
	input wire logic ser_in_a,
	input wire logic ser_in_b,
	input wire logic ser_in_c,
	input wire logic ser_in_d,
	input wire logic xfer_strobe_a_n,
	input wire logic xfer_strobe_b_n,
	input wire logic xfer_strobe_c_n,
	input wire logic xfer_strobe_d_n,
	output logic [qdsl_pkg::QDSL_WORD_W-1:0] hold_a,
	output logic [qdsl_pkg::QDSL_WORD_W-1:0] hold_b,
	output logic [qdsl_pkg::QDSL_WORD_W-1:0] hold_c,
	output logic [qdsl_pkg::QDSL_WORD_W-1:0] hold_d
);
	import qdsl_pkg::*;

	typedef logic [QDSL_WORD_W-1:0] qdsl_word_t;

	// Word is usable once two successive samples agree
	function automatic logic qdsl_word_stable(input qdsl_word_t now_w, input qdsl_word_t prev_w);
		return now_w == prev_w;
	endfunction

	logic rst_s1_q;
	logic rst_s2_q;
	logic rst_s1_d;
	logic rst_s2_d;
	logic rst_sys_b;

	logic [QDSL_NUM_CH-1:0] chan_clk;
	logic [QDSL_NUM_CH-1:0] ser_in_v;
	logic [QDSL_NUM_CH-1:0] strobe_raw_n;
	qdsl_word_t shift_word [QDSL_NUM_CH];

	logic [QDSL_NUM_CH-1:0] strobe_s1_q;
	logic [QDSL_NUM_CH-1:0] strobe_s2_q;
	logic [QDSL_NUM_CH-1:0] strobe_s1_d;
	logic [QDSL_NUM_CH-1:0] strobe_s2_d;
	qdsl_word_t word_s1_q [QDSL_NUM_CH];
	qdsl_word_t word_s2_q [QDSL_NUM_CH];
	qdsl_word_t word_s3_q [QDSL_NUM_CH];
	qdsl_word_t word_s1_d [QDSL_NUM_CH];
	qdsl_word_t word_s2_d [QDSL_NUM_CH];
	qdsl_word_t word_s3_d [QDSL_NUM_CH];
	qdsl_word_t hold_q [QDSL_NUM_CH];
	qdsl_word_t hold_nx_d [QDSL_NUM_CH];

	// Reset release through two flip-flops
	always_comb begin
		rst_s1_d = 1'b1;
		rst_s2_d = rst_s1_q;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= rst_s1_d;
			rst_s2_q <= rst_s2_d;
		end
	end

	assign rst_sys_b = rst_s2_q;

	// Shared variant drives all four channels from the shift_clk_a pin inside
	assign chan_clk[0] = shift_clk_a;
	assign chan_clk[1] = SHARED_CLK ? shift_clk_a : shift_clk_b;
	assign chan_clk[2] = SHARED_CLK ? shift_clk_a : shift_clk_c;
	assign chan_clk[3] = SHARED_CLK ? shift_clk_a : shift_clk_d;

	assign ser_in_v = {ser_in_d, ser_in_c, ser_in_b, ser_in_a};
	assign strobe_raw_n = {xfer_strobe_d_n, xfer_strobe_c_n, xfer_strobe_b_n, xfer_strobe_a_n};

	for (genvar i = 0; i < QDSL_NUM_CH; i++) begin : g_chan
		qdsl_shift_chan #(
			.WORD_W(QDSL_WORD_W)
		) u_chan (
			.link_clk(chan_clk[i]),
			.rst_b(rst_sys_b),
			.ser_in(ser_in_v[i]),
			.word(shift_word[i])
		);
	end

	// Strobes and words cross into the system clock
	always_comb begin
		strobe_s1_d = strobe_raw_n;
		strobe_s2_d = strobe_s1_q;
		for (int i = 0; i < QDSL_NUM_CH; i++) begin
			word_s1_d[i] = shift_word[i];
			word_s2_d[i] = word_s1_q[i];
			word_s3_d[i] = word_s2_q[i];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sys_b) begin
		if (!rst_sys_b) begin
			strobe_s1_q <= {QDSL_NUM_CH{QDSL_STROBE_RST}};
			strobe_s2_q <= {QDSL_NUM_CH{QDSL_STROBE_RST}};
			for (int i = 0; i < QDSL_NUM_CH; i++) begin
				word_s1_q[i] <= QDSL_WORD_RST;
				word_s2_q[i] <= QDSL_WORD_RST;
				word_s3_q[i] <= QDSL_WORD_RST;
			end
		end else begin
			strobe_s1_q <= strobe_s1_d;
			strobe_s2_q <= strobe_s2_d;
			for (int i = 0; i < QDSL_NUM_CH; i++) begin
				word_s1_q[i] <= word_s1_d[i];
				word_s2_q[i] <= word_s2_d[i];
				word_s3_q[i] <= word_s3_d[i];
			end
		end
	end

	// Holding registers: load while strobe low and the word is stable, hold otherwise
	always_comb begin
		for (int i = 0; i < QDSL_NUM_CH; i++) begin
			hold_nx_d[i] = hold_q[i];
			if (!strobe_s2_q[i] && qdsl_word_stable(word_s2_q[i], word_s3_q[i])) begin
				hold_nx_d[i] = word_s2_q[i];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sys_b) begin
		if (!rst_sys_b) begin
			for (int i = 0; i < QDSL_NUM_CH; i++) begin
				hold_q[i] <= QDSL_WORD_RST;
			end
		end else begin
			for (int i = 0; i < QDSL_NUM_CH; i++) begin
				hold_q[i] <= hold_nx_d[i];
			end
		end
	end

	assign hold_a = hold_q[0];
	assign hold_b = hold_q[1];
	assign hold_c = hold_q[2];
	assign hold_d = hold_q[3];
endmodule

// file: bench/qdsl_checker.sv
// Checker tying each holding output to its transfer strobe
module qdsl_checker (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic xfer_strobe_a_n,
	input wire logic xfer_strobe_b_n,
	input wire logic xfer_strobe_c_n,
	input wire logic xfer_strobe_d_n,
	input wire logic [11:0] hold_a,
	input wire logic [11:0] hold_b,
	input wire logic [11:0] hold_c,
	input wire logic [11:0] hold_d
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	AST_HA: assert property (xfer_strobe_a_n [*5] |-> $stable(hold_a)) else $error("hold_a moved");
	AST_HB: assert property (xfer_strobe_b_n [*5] |-> $stable(hold_b)) else $error("hold_b moved");
	AST_HC: assert property (xfer_strobe_c_n [*5] |-> $stable(hold_c)) else $error("hold_c moved");
	AST_HD: assert property (xfer_strobe_d_n [*5] |-> $stable(hold_d)) else $error("hold_d moved");
	AST_UA: assert property ($changed(hold_a) |-> !$past(xfer_strobe_a_n, 2) || !$past(xfer_strobe_a_n, 3))
		else $error("hold_a unstrobed");
	AST_UB: assert property ($changed(hold_b) |-> !$past(xfer_strobe_b_n, 2) || !$past(xfer_strobe_b_n, 3))
		else $error("hold_b unstrobed");
	AST_UC: assert property ($changed(hold_c) |-> !$past(xfer_strobe_c_n, 2) || !$past(xfer_strobe_c_n, 3))
		else $error("hold_c unstrobed");
	AST_UD: assert property ($changed(hold_d) |-> !$past(xfer_strobe_d_n, 2) || !$past(xfer_strobe_d_n, 3))
		else $error("hold_d unstrobed");
endmodule

bind qdsl_top qdsl_checker chk (.sys_clk, .rst_b, .xfer_strobe_a_n, .xfer_strobe_b_n, .xfer_strobe_c_n,
	.xfer_strobe_d_n, .hold_a, .hold_b, .hold_c, .hold_d);

// file: bench/qdsl_host.sv
// Host serial port model: clocked frames, then strobes
module qdsl_host (
	output logic [3:0] ck,
	output logic [3:0] sd,
	output logic [3:0] ld
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ck = 4'h0;
		sd = 4'h0;
		ld = 4'hf;
	end
	// Two lead bits absorb the reset edges
	task automatic send(input logic [3:0][11:0] w, input logic [3:0] mc, input logic [3:0] ml);
		for (int i = 13; i >= 0; i--) begin
			for (int k = 0; k < 4; k++) sd[k] = w[k][i % 12];
			#16 ck = mc;
			#16 ck = 4'h0;
		end
		sd = ~sd;
		#30 ld = ~ml;
		#130 ld = 4'hf;
	endtask
endmodule

// file: bench/tb_quad_dac_serial_load.sv
// One directed frame then random frames through the host model, holding outputs compared
module tb_quad_dac_serial_load;
	timeunit 1ns;
	timeprecision 1ps;
	import qdsl_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] ck, sd, ld, mc, ml;
	logic [3:0][11:0] hold, sr, ex, w;
	logic [3:0][11:0] hold_s, sr_s, ex_s;
	int n_mismatch = 0;
	int cmp_count = 0;
	always #2.5 sys_clk = ~sys_clk;
	qdsl_host host (.ck(ck), .sd(sd), .ld(ld));
	qdsl_top uut (.sys_clk(sys_clk), .rst_b(rst_b), .shift_clk_a(ck[0]), .shift_clk_b(ck[1]), .shift_clk_c(ck[2]),
		.shift_clk_d(ck[3]), .ser_in_a(sd[0]), .ser_in_b(sd[1]), .ser_in_c(sd[2]), .ser_in_d(sd[3]),
		.xfer_strobe_a_n(ld[0]), .xfer_strobe_b_n(ld[1]), .xfer_strobe_c_n(ld[2]), .xfer_strobe_d_n(ld[3]),
		.hold_a(hold[0]), .hold_b(hold[1]), .hold_c(hold[2]), .hold_d(hold[3]));
	// Shared-clock variant: only the first clock pin is used
	qdsl_top #(.SHARED_CLK(1'b1)) uut_sh (.sys_clk(sys_clk), .rst_b(rst_b), .shift_clk_a(ck[0]),
		.shift_clk_b(ck[1]), .shift_clk_c(ck[2]), .shift_clk_d(ck[3]),
		.ser_in_a(sd[0]), .ser_in_b(sd[1]), .ser_in_c(sd[2]), .ser_in_d(sd[3]),
		.xfer_strobe_a_n(ld[0]), .xfer_strobe_b_n(ld[1]), .xfer_strobe_c_n(ld[2]), .xfer_strobe_d_n(ld[3]),
		.hold_a(hold_s[0]), .hold_b(hold_s[1]), .hold_c(hold_s[2]), .hold_d(hold_s[3]));
	function automatic logic [3:0][11:0] nxt(input logic [3:0][11:0] o, input logic [3:0][11:0] n, input logic [3:0] m);
		for (int k = 0; k < 4; k++) if (m[k]) o[k] = n[k];
		return o;
	endfunction
	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic check();
		for (int k = 0; k < 4; k++) begin
			cmp_count++;
			if (hold[k] !== ex[k]) begin
				n_mismatch++;
				$display("unexpected hold %0d expected %h seen %h", k, ex[k], hold[k]);
			end
			cmp_count++;
			if (hold_s[k] !== ex_s[k]) begin
				n_mismatch++;
				$display("unexpected shared hold %0d expected %h seen %h", k, ex_s[k], hold_s[k]);
			end
		end
	endtask
	initial begin
		ex = {4{QDSL_WORD_RST}};
		sr = ex;
		ex_s = ex;
		sr_s = ex;
		void'($urandom(32'hc6805a2b));
		repeat (3) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge sys_clk);
		check();
		for (int n = 0; n < 24; n++) begin
			w = n == 0 ? {12'h800, 12'h001, 12'hfff, 12'h000} : 48'({$urandom, $urandom});
			mc = n == 0 ? 4'hf : 4'($urandom);
			ml = n == 0 ? 4'hf : 4'($urandom);
			@(negedge sys_clk);
			host.send(w, mc, ml);
			sr = nxt(sr, w, mc);
			ex = nxt(ex, sr, ml);
			sr_s = nxt(sr_s, w, {4{mc[0]}});
			ex_s = nxt(ex_s, sr_s, ml);
			#20 check();
		end
		tally_and_finish();
	end
	initial begin
		#100us n_mismatch++;
		tally_and_finish();
	end
endmodule
